/* File: core/esv_pkg.sv */
package esv_pkg;
   // register word addresses on the bus
   localparam logic [11:0] OFF_STATE = 12'h004;
   localparam logic [11:0] OFF_VBASE = 12'h008;
   localparam logic [11:0] OFF_APPCTL = 12'h00c;
   // interrupt_control_state field positions
   localparam int unsigned STAT_TICK_SET = 26;
   localparam int unsigned STAT_TICK_CLR = 25;
   localparam int unsigned STAT_DBG = 23;
   localparam int unsigned STAT_IRQ_PEND = 22;
   localparam int unsigned STAT_PEND_VEC_LSB = 12;
   localparam int unsigned STAT_RET_BASE = 11;
   // app_irq_reset_control field positions and key values
   localparam int unsigned APP_KEY_LSB = 16;
   localparam int unsigned APP_GRP_LSB = 8;
   localparam logic [15:0] KEY_WRITE = 16'h05fa;
   localparam logic [15:0] KEY_READ = 16'hfa05;
   localparam logic [2:0] PRI_GROUP_RESET = 3'h0;
   // vector_table_base layout and reset value
   localparam int unsigned VBASE_LSB = 7;
   localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
   // exception numbers
   localparam logic [8:0] EXC_NONE = 9'h000;
   localparam logic [8:0] EXC_NMI = 9'h002;
   localparam logic [8:0] EXC_HARD = 9'h003;
   localparam int unsigned EXC_TICK = 15;
   localparam int unsigned EXC_FIRST_IRQ = 16;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {BANK_S = 1'b0, BANK_NS = 1'b1} esv_bank_t;
   typedef enum logic [1:0] {REG_NONE = 2'b00, REG_STATE = 2'b01, REG_VBASE = 2'b10,
      REG_APPCTL = 2'b11} esv_reg_t;
   typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} esv_wr_state_t;
endpackage : esv_pkg

/* File: core/esv_sel_if.sv */
`timescale 1ns/1ps
interface esv_sel_if #(
   parameter int NUM_EXC = 48,
   parameter int PRIO_W = 3
);
   logic [NUM_EXC-1:0] pend;
   logic [NUM_EXC-1:0] en;
   logic [NUM_EXC*PRIO_W-1:0] prio;
   logic [PRIO_W-1:0] base_priority_mask;
   logic fault_mask_a;
   logic [8:0] vect;
   logic irqPend;

   modport sel (
      input pend,
      input en,
      input prio,
      input base_priority_mask,
      input fault_mask_a,
      output vect,
      output irqPend
   );
   modport req (
      output pend,
      output en,
      output prio,
      output base_priority_mask,
      output fault_mask_a,
      input vect,
      input irqPend
   );
endinterface : esv_sel_if

/* File: core/esv_pend_sel.sv */
`timescale 1ns/1ps
module esv_pend_sel #(
   parameter int NUM_EXC = 48,
   parameter int PRIO_W = 3
) (
   // selection request and result
   esv_sel_if.sel sel
);
   import esv_pkg::*;

   logic [NUM_EXC-1:0] eligible;
   logic [8:0] best;
   logic [PRIO_W-1:0] bestPrio;
   logic found;

   // base priority and fault mask gate, general mask deliberately not seen here
   always_comb
   begin
      for (int i = 0; i < NUM_EXC; i++)
      begin
         if (sel.fault_mask_a)
            eligible[i] = sel.pend[i] && (i == 2 || i == 3); // R8
         else
            eligible[i] = sel.pend[i] && sel.en[i] && i != 0 && (sel.base_priority_mask == '0 ||
               sel.prio[i*PRIO_W +: PRIO_W] < sel.base_priority_mask); // R8
      end
   end

   // lowest priority value wins, ties go to the lower number; nmi and hard fault on top
   always_comb
   begin
      best = EXC_NONE;
      bestPrio = '0;
      found = 1'b0;
      for (int i = NUM_EXC - 1; i > 0; i--)
      begin
         if (eligible[i] && (!found || sel.prio[i*PRIO_W +: PRIO_W] <= bestPrio))
         begin
            best = 9'(i);
            bestPrio = sel.prio[i*PRIO_W +: PRIO_W];
            found = 1'b1;
         end
      end
      if (eligible[3])
         best = EXC_HARD;
      if (eligible[2])
         best = EXC_NMI;
   end

   assign sel.vect = best; // R7
   assign sel.irqPend = |sel.pend[NUM_EXC-1:EXC_FIRST_IRQ]; // R6
endmodule : esv_pend_sel

/* File: core/esv_regs.sv */
// Contract
// R1 - write 1 bit 26 pends tick; reads pending
// R2 - tick set-pending kept per security state
// R3 - write 1 bit 25 clears tick pending
// R4 - tick clear is write-only, shared
// R5 - bit 23 reads zero outside debug
// R6 - bit 22 flags any interrupt pending
// R7 - bits 20:12 give highest pending vector
// R8 - selection honours base and fault masks
// R9 - bit 11 set unless preempted actives remain
// R10 - bits 8:0 give active exception, thread zero
// R11 - active field mirrors status word low bits
// R12 - software never sets and clears together
// R13 - vector base holds table offset from zero
// R14 - offset field bits 31:7 give offset
// R15 - vector base bits 6:0 read zero
// R16 - software aligns offset to table size
// R17 - one vector base copy for both states
// R18 - reset control writes need key 0x5fa
// R19 - reset control banked bit by bit
// R20 - key field reads fixed status value
// R21 - reserved status bits read zero, ignore writes
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module esv_regs #(
   parameter int NUM_EXC = 48,
   parameter int PRIO_W = 3
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // exception state from the core
   input wire logic [NUM_EXC-1:0] excPending,
   input wire logic [NUM_EXC-1:0] excEnabled,
   input wire logic [NUM_EXC*PRIO_W-1:0] excPrio,
   input wire logic [NUM_EXC-1:0] excActive,
   input wire logic [8:0] excStatusWord,
   input wire logic [PRIO_W-1:0] basePriorityMask,
   input wire logic faultMaskA,
   input wire logic [1:0] tickEvent,
   input wire logic [1:0] tickTaken,
   // debug view
   input wire logic debugHalted,
   input wire logic debugPendHint,
   // configuration to the core
   output logic [1:0] tickPending,
   output logic [31:0] vectorTableBase,
   output logic [2:0] priGroupSecure,
   output logic [2:0] priGroupNonSecure
);
   import esv_pkg::*;

   function automatic esv_reg_t decodeReg(input logic [11:0] addr);
      logic [11:0] word;
      word = {addr[11:2], 2'b00};
      if (word == OFF_STATE)
         return REG_STATE;
      else if (word == OFF_VBASE)
         return REG_VBASE;
      else if (word == OFF_APPCTL)
         return REG_APPCTL;
      else
         return REG_NONE;
   endfunction : decodeReg

   function automatic logic [31:0] strbMask(input logic [3:0] strb);
      return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : strbMask

   // bus holding registers
   esv_wr_state_t wrState_r;
   esv_wr_state_t wrState_nxt;
   logic awHeld_r;
   logic wHeld_r;
   logic [11:0] awAddr_r;
   esv_bank_t awBank_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // architectural state
   logic [1:0] tickPend_r;
   logic [1:0] tickPend_nxt;
   logic [31:VBASE_LSB] tableOffset_r;
   logic [2:0] priGroup_r [2];

   // decode wires
   logic awTake;
   logic wTake;
   logic doWrite;
   esv_reg_t wrReg;
   logic [31:0] wrData;
   logic keyOk;
   logic wrStatus;
   logic wrVbase;
   logic wrAppctl;
   logic wrMapped;
   logic tickSetWr;
   logic tickClrWr;
   esv_reg_t rdReg;
   esv_bank_t rdBank;
   logic arTake;
   logic return_to_base_flag;
   logic debugBit;
   logic [31:0] statusView;
   logic [31:0] vbaseView;
   logic [31:0] appctlView;
   logic [31:0] readMux;
   logic rdMapped;
   logic [NUM_EXC-1:0] selPend;
   logic tickAny;

   esv_sel_if #(.NUM_EXC(NUM_EXC), .PRIO_W(PRIO_W)) selBus ();

   esv_pend_sel #(.NUM_EXC(NUM_EXC), .PRIO_W(PRIO_W)) u_sel (
      .sel(selBus.sel)
   );

   // the tick exception is pending to the selector while either bank holds it
   assign tickAny = |tickPend_r;
   always_comb
   begin
      selPend = excPending;
      selPend[EXC_TICK] = excPending[EXC_TICK] | tickAny;
   end

   assign selBus.pend = selPend;
   assign selBus.en = excEnabled;
   assign selBus.prio = excPrio;
   assign selBus.base_priority_mask = basePriorityMask; // R8
   assign selBus.fault_mask_a = faultMaskA; // R8

   // write channel: address and data may arrive in either order
   assign awready = !awHeld_r && wrState_r == WR_IDLE;
   assign wready = !wHeld_r && wrState_r == WR_IDLE;
   assign awTake = awvalid && awready;
   assign wTake = wvalid && wready;
   assign doWrite = awHeld_r && wHeld_r && wrState_r == WR_IDLE;
   assign wrReg = decodeReg(awAddr_r);
   assign wrData = wData_r & strbMask(wStrb_r);
   // strobes gate the key too, so a write without both key byte strobes never unlocks the register
   assign keyOk = wrData[31:APP_KEY_LSB] == KEY_WRITE; // R18
   assign wrMapped = wrReg != REG_NONE;
   assign wrStatus = doWrite && wrReg == REG_STATE;
   assign wrVbase = doWrite && wrReg == REG_VBASE;
   assign wrAppctl = doWrite && wrReg == REG_APPCTL && keyOk; // R18 R20
   assign tickSetWr = wrStatus && wrData[STAT_TICK_SET]; // R1
   assign tickClrWr = wrStatus && wrData[STAT_TICK_CLR]; // R3

   always_comb
   begin
      wrState_nxt = wrState_r;
      case (wrState_r)
         WR_IDLE:
         begin
            if (doWrite)
               wrState_nxt = WR_RESP;
         end
         WR_RESP:
         begin
            if (bready)
               wrState_nxt = WR_IDLE;
         end
         default:
            wrState_nxt = WR_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wrState_r <= WR_IDLE;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         awBank_r <= BANK_S;
         wData_r <= '0;
         wStrb_r <= '0;
         bresp_r <= RESP_OKAY;
      end
      else
      begin
         wrState_r <= wrState_nxt;
         if (awTake)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
            awBank_r <= esv_bank_t'(awprot[1]);
         end
         if (wTake)
         begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (doWrite)
         begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign bvalid = wrState_r == WR_RESP;
   assign bresp = bresp_r;

   // tick pending: timer event wins over a clear in the same cycle
   always_comb
   begin
      tickPend_nxt = tickPend_r;
      for (int b = 0; b < 2; b++)
      begin
         if (tickClrWr || tickTaken[b])
            tickPend_nxt[b] = 1'b0; // R3 R4
         if (tickSetWr && awBank_r == esv_bank_t'(1'(b)))
            tickPend_nxt[b] = 1'b1; // R1 R2
         if (tickEvent[b])
            tickPend_nxt[b] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         tickPend_r <= '0;
      else
         tickPend_r <= tickPend_nxt;
   end

   // one table base for both states; low bits are not stored at all
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         tableOffset_r <= VBASE_RESET[31:VBASE_LSB];
      else if (wrVbase)
         tableOffset_r <= wrData[31:VBASE_LSB]; // R13 R14 R17
   end

   // grouping field banked per state, key field shared and never stored
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         priGroup_r[0] <= PRI_GROUP_RESET;
         priGroup_r[1] <= PRI_GROUP_RESET;
      end
      else if (wrAppctl)
         priGroup_r[awBank_r] <= wrData[APP_GRP_LSB +: 3]; // R19
   end

   // read channel: one outstanding read, answered the cycle after it is taken
   assign arready = !rvalid_r;
   assign arTake = arvalid && arready;
   assign rdReg = decodeReg(araddr);
   assign rdBank = esv_bank_t'(arprot[1]);
   assign return_to_base_flag = (excActive & (excActive - 1'b1)) == '0; // R9
   assign debugBit = debugHalted && debugPendHint; // R5

   assign statusView = {
      5'h00,
      tickPend_r[rdBank], // R1 R2
      1'b0, // R4
      1'b0, // R21
      debugBit, // R5
      selBus.irqPend, // R6
      1'b0, // R21
      selBus.vect, // R7
      return_to_base_flag, // R9
      2'h0, // R21
      excStatusWord // R10 R11
   };
   assign vbaseView = {
      tableOffset_r, // R14
      7'h00 // R15
   };
   assign appctlView = {
      KEY_READ, // R20
      5'h00,
      priGroup_r[rdBank], // R19
      8'h00
   };
   assign rdMapped = rdReg != REG_NONE;

   // read data is latched at acceptance, so a moving core view cannot tear a response
   assign readMux = (rdReg == REG_STATE) ? statusView :
                    (rdReg == REG_VBASE) ? vbaseView :
                    (rdReg == REG_APPCTL) ? appctlView : 32'h0000_0000;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end
      else if (arTake)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= readMux;
         rresp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
         rvalid_r <= 1'b0;
   end

   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // outputs to the core
   assign tickPending = tickPend_r;
   assign vectorTableBase = vbaseView; // R13
   assign priGroupSecure = priGroup_r[0];
   assign priGroupNonSecure = priGroup_r[1];
endmodule : esv_regs

/* File: verif/esv_regs_asserts.sv */
`timescale 1ns/1ps
module esv_regs_asserts
   import esv_pkg::*;
#(
   parameter int NUM_EXC = 48,
   parameter int PRIO_W = 3
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // bus handshakes
   input wire logic awready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [11:0] araddr,
   input wire logic [31:0] rdata,
   // core side
   input wire logic [NUM_EXC-1:0] excPending,
   input wire logic [NUM_EXC-1:0] excActive,
   input wire logic [8:0] excStatusWord,
   input wire logic debugHalted,
   input wire logic debugPendHint,
   input wire logic [1:0] tickEvent,
   input wire logic [1:0] tickTaken,
   input wire logic [1:0] tickPending,
   input wire logic [31:0] vectorTableBase
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire logic statusRd = arvalid && arready && araddr[11:2] == OFF_STATE[11:2];
   wire logic vbaseRd = arvalid && arready && araddr[11:2] == OFF_VBASE[11:2];
   wire logic keyRd = arvalid && arready && araddr[11:2] == OFF_APPCTL[11:2];
   wire logic anyIrq = |excPending[NUM_EXC-1:16];
   wire logic dbgOn = debugHalted && debugPendHint;
   // a single active exception still counts as back at base
   wire logic oneAct = $countones(excActive) <= 1;

   tick_event_a: assert property (tickEvent[0] |=> tickPending[0])
      else $error("tick event did not pend");
   tick_taken_a: assert property (tickTaken[1] && !tickEvent[1] && awready |=> !tickPending[1])
      else $error("tick taken did not clear");
   vbase_low_zero_a: assert property (vectorTableBase[6:0] == 7'h00)
      else $error("vector base low bits set");
   vbase_hold_a: assert property ($changed(vectorTableBase) |-> !$past(awready))
      else $error("vector base moved without a write");
   active_field_a: assert property (statusRd |=> rdata[8:0] == $past(excStatusWord))
      else $error("active field mismatch");
   reserved_zero_a: assert property (statusRd |=> rdata[31:27] == 5'h00 && !rdata[24]
      && !rdata[21] && rdata[10:9] == 2'h0) else $error("reserved status bits set");
   irq_flag_a: assert property (statusRd |=> rdata[22] == $past(anyIrq))
      else $error("irq pending flag mismatch");
   debug_bit_a: assert property (statusRd |=> rdata[23] == $past(dbgOn))
      else $error("debug bit mismatch");
   ret_base_a: assert property (statusRd |=> rdata[11] == $past(oneAct))
      else $error("return to base mismatch");
   vbase_read_a: assert property (vbaseRd |=> rdata == $past(vectorTableBase))
      else $error("vector base read mismatch");
   key_read_a: assert property (keyRd |=> rdata[31:16] == KEY_READ)
      else $error("key status mismatch");
endmodule : esv_regs_asserts

bind esv_regs esv_regs_asserts #(.NUM_EXC(NUM_EXC), .PRIO_W(PRIO_W)) esv_regs_asserts_i (
   .clock(clock), .arst_n(arst_n), .awready(awready), .arvalid(arvalid), .arready(arready),
   .araddr(araddr), .rdata(rdata), .excPending(excPending), .excActive(excActive),
   .excStatusWord(excStatusWord), .debugHalted(debugHalted), .debugPendHint(debugPendHint),
   .tickEvent(tickEvent), .tickTaken(tickTaken), .tickPending(tickPending),
   .vectorTableBase(vectorTableBase)
);

/* File: verif/esv_tb.sv */
`timescale 1ns/1ps
module tb;
   import esv_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [2:0] awprot = 3'h0, arprot = 3'h0, basePriorityMask = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [47:0] excPending = '0, excEnabled = '1, excActive = '0;
   // exception 17 is the only urgent one, everything else sits at 3
   logic [143:0] excPrio = {{30{3'h3}}, 3'h1, {17{3'h3}}};
   logic [8:0] excStatusWord = 9'h000;
   logic faultMaskA = 1'b0, debugHalted = 1'b0, debugPendHint = 1'b0;
   logic [1:0] tickEvent = 2'h0, tickTaken = 2'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, tickPending;
   logic [31:0] rdata, vectorTableBase;
   logic [2:0] priGroupSecure, priGroupNonSecure;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'h0aad1256;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   logic [65:0] e;
   localparam logic [31:0] TICK_M = 32'h0400_0000;

   esv_regs esv_regs_i (
      .clock(clock), .arst_n(arst_n),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .excPending(excPending), .excEnabled(excEnabled), .excPrio(excPrio),
      .excActive(excActive), .excStatusWord(excStatusWord),
      .basePriorityMask(basePriorityMask), .faultMaskA(faultMaskA),
      .tickEvent(tickEvent), .tickTaken(tickTaken),
      .debugHalted(debugHalted), .debugPendHint(debugPendHint),
      .tickPending(tickPending), .vectorTableBase(vectorTableBase),
      .priGroupSecure(priGroupSecure), .priGroupNonSecure(priGroupNonSecure)
   );

   always #2.5 clock = ~clock;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task final_report;
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic ns, input logic [1:0] er);
      bq.push_back(er);
      @(posedge clock);
      awvalid <= 1'b1;
      awaddr <= a;
      awprot <= {1'b0, ns, 1'b0};
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic ns, input logic [31:0] x,
      input logic [31:0] m, input logic [1:0] er);
      rq.push_back({er, m, x & m});
      @(posedge clock);
      arvalid <= 1'b1;
      araddr <= a;
      arprot <= {1'b0, ns, 1'b0};
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd

   // drives the core view, then reads the status word with a random bank and active number
   task automatic fld(input logic [47:0] p, input logic [2:0] bp, input logic fm,
      input logic [47:0] act, input logic dbg, input logic [8:0] v, input logic irq, input logic rb);
      rnd = lfsr(rnd);
      @(posedge clock);
      excPending <= p;
      basePriorityMask <= bp;
      faultMaskA <= fm;
      excActive <= act;
      debugHalted <= dbg;
      debugPendHint <= 1'b1;
      excStatusWord <= rnd[8:0];
      rd(OFF_STATE, rnd[9], {8'h0, dbg, irq, 1'b0, v, rb, 2'b0, rnd[8:0]}, 32'hfdff_ffff, RESP_OKAY);
   endtask : fld

   always @(posedge clock)
   begin
      cycles++;
      if (rvalid && rready)
      begin
         e = rq.pop_front();
         check("rdata", rdata & e[63:32], e[31:0]);
         check("rresp", {30'h0, rresp}, {30'h0, e[65:64]});
      end
      if (bvalid && bready)
         check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
      if (cycles == 20000)
      begin
         n_errors++;
         final_report();
      end
   end

   initial
   begin
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      rd(OFF_VBASE, 1'b0, VBASE_RESET, '1, RESP_OKAY);
      rd(OFF_APPCTL, 1'b0, {KEY_READ, 16'h0}, '1, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         wr(OFF_VBASE, {rnd[31:8], 8'h00}, 4'hf, i[0], RESP_OKAY);
         rd(OFF_VBASE, ~i[0], {rnd[31:8], 8'h00}, '1, RESP_OKAY);
      end
      @(negedge clock);
      check("vbase", vectorTableBase, {rnd[31:8], 8'h00});
      wr(OFF_STATE, TICK_M, 4'hf, 1'b0, RESP_OKAY);
      wr(OFF_STATE, 32'h0, 4'hf, 1'b0, RESP_OKAY);
      wr(OFF_STATE, TICK_M, 4'h7, 1'b1, RESP_OKAY);
      rd(OFF_STATE, 1'b0, TICK_M, TICK_M, RESP_OKAY);
      rd(OFF_STATE, 1'b1, 32'h0, TICK_M, RESP_OKAY);
      wr(OFF_STATE, 32'h0200_0000, 4'hf, 1'b1, RESP_OKAY);
      rd(OFF_STATE, 1'b0, 32'h0, TICK_M, RESP_OKAY);
      @(posedge clock);
      tickEvent <= 2'b11;
      @(posedge clock);
      tickEvent <= 2'b00;
      rd(OFF_STATE, 1'b1, TICK_M, TICK_M, RESP_OKAY);
      rd(OFF_STATE, 1'b0, TICK_M, TICK_M, RESP_OKAY);
      @(posedge clock);
      tickTaken <= 2'b10;
      @(posedge clock);
      tickTaken <= 2'b00;
      rd(OFF_STATE, 1'b1, 32'h0, TICK_M, RESP_OKAY);
      rd(OFF_STATE, 1'b0, TICK_M, TICK_M, RESP_OKAY);
      @(posedge clock);
      tickTaken <= 2'b01;
      @(posedge clock);
      tickTaken <= 2'b00;
      @(negedge clock);
      check("tick", {30'h0, tickPending}, 32'h0);
      fld(48'h0, 3'h0, 1'b0, 48'h0, 1'b0, 9'd0, 1'b0, 1'b1);
      fld(48'h12_0000, 3'h0, 1'b0, 48'h30, 1'b1, 9'd17, 1'b1, 1'b0);
      fld(48'h10_0000, 3'h2, 1'b0, 48'h10, 1'b0, 9'd0, 1'b1, 1'b1);
      fld(48'h10_0000, 3'h4, 1'b0, 48'h0, 1'b0, 9'd20, 1'b1, 1'b1);
      fld(48'h10_0008, 3'h0, 1'b1, 48'h0, 1'b0, 9'd3, 1'b1, 1'b1);
      wr(OFF_APPCTL, 32'h05fa_0500, 4'hf, 1'b0, RESP_OKAY);
      rd(OFF_APPCTL, 1'b0, 32'hfa05_0500, '1, RESP_OKAY);
      rd(OFF_APPCTL, 1'b1, 32'hfa05_0000, '1, RESP_OKAY);
      wr(OFF_APPCTL, 32'h1234_0300, 4'hf, 1'b1, RESP_OKAY);
      rd(OFF_APPCTL, 1'b1, 32'hfa05_0000, '1, RESP_OKAY);
      @(negedge clock);
      check("group", {29'h0, priGroupSecure}, 32'h5);
      check("groupns", {29'h0, priGroupNonSecure}, 32'h0);
      wr(OFF_APPCTL, 32'h05fa_0300, 4'hf, 1'b1, RESP_OKAY);
      rd(OFF_APPCTL, 1'b1, 32'hfa05_0300, '1, RESP_OKAY);
      rd(OFF_APPCTL, 1'b0, 32'hfa05_0500, '1, RESP_OKAY);
      @(negedge clock);
      check("groupns", {29'h0, priGroupNonSecure}, 32'h3);
      check("group", {29'h0, priGroupSecure}, 32'h5);
      wr(12'h100, rnd, 4'hf, 1'b0, RESP_SLVERR);
      rd(12'h100, 1'b0, 32'h0, '1, RESP_SLVERR);
      repeat (3) @(posedge clock);
      final_report();
   end
endmodule : tb
